// >>> src/gpio_port_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH
`define OFS_PIN_DATA_DIR   12'h1E4
`define OFS_PIN_EVT_STS_EN 12'h1E8
`define OFS_PIN_CFG        12'h1EC
`define OFS_SYS_EVT        12'h1F0
`define DATA_LSB           0
`define DIR_LSB            16
`define FLAG_LSB           0
`define PEN_LSB            16
`define DRV_LSB            0
`define TSOE_LSB           8
`define POL_LSB            16
`define PORT_EN_BIT        0
`define RST_BYTE           8'h00
`define CLK_PERIOD_NS      40
`define MIN_LEVEL_NS       40
`define MIN_LEVEL_CYC      ((`MIN_LEVEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> src/gpio_port_pkg.sv
// Types shared by the port design
package gpio_port_pkg;
  typedef enum logic [1:0] {
    APB_IDLE,
    APB_SETUP,
    APB_ACCESS
  } apb_phase_t;
endpackage

// >>> src/gpio_sync2.sv
// Two-flop synchroniser for one bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module gpio_sync2 #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;  // First stage, read only by second stage

  // Shift the pin level through two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// >>> src/gpio_data_direction_irq.sv
// Eight-pin general-purpose I/O port with level events, APB slave
//
// The implementer's own choice: the APB interface to the registers.
`include "gpio_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gpio_data_direction_irq #(
  parameter int NPINS = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic [NPINS-1:0] pin_in,
  output var  logic [NPINS-1:0] pin_out,
  output var  logic [NPINS-1:0] pin_oe,
  output var  logic             port_event,
  output var  logic             irq
);

  // Software-visible state
  logic [NPINS-1:0] pin_direction_bits_ff;   // 1 = output
  logic [NPINS-1:0] pin_data_bits_ff;        // Last written data
  logic [NPINS-1:0] pin_event_flags_ff;      // Sticky level events
  logic [NPINS-1:0] pin_event_en_ff;         // Per-pin enables
  logic [NPINS-1:0] pin_driver_type_ff;      // 1 push/pull, 0 open drain
  logic [NPINS-1:0] ts_output_en_ff;         // Timestamp output override
  logic [NPINS-1:0] pin_trigger_polarity_ff; // 1 high active
  logic             port_event_en_ff;        // System port enable, gates irq only, not port_event
  logic             sys_evt_sts_ff;          // Sticky, read clears
  logic             sys_evt_mask_ff;         // Mask for irq output

  // Derived signals
  logic [NPINS-1:0] pin_sync;      // Synchronised pin levels
  logic [NPINS-1:0] eff_output;    // Effective direction per pin
  logic [NPINS-1:0] level_active;  // Active level this cycle
  logic [NPINS-1:0] hold_ok;       // Level held long enough
  logic [NPINS-1:0] nxt_flags;     // Next event flags
  logic [NPINS-1:0] nxt_out;       // Next pin output value
  logic [NPINS-1:0] nxt_oe;        // Next pin output enable
  logic [NPINS-1:0] rd_data_bits;  // Data field read view
  logic             wr_en;         // Write taken this cycle
  logic             rd_en;         // Read taken this cycle
  logic             addr_ok;       // Address is mapped
  logic [31:0]      nxt_prdata;    // Read mux
  logic             nxt_port_event;
  gpio_port_pkg::apb_phase_t phase_ff;  // Observed bus phase

  // Pins sampled through two flops before any use
  gpio_sync2 #(.W(NPINS)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_in),
    .q       (pin_sync)
  );

  // Bus phase tracker, informational for covers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= gpio_port_pkg::APB_IDLE;
    end else begin
      case (phase_ff)
        gpio_port_pkg::APB_IDLE:
          phase_ff <= psel ? gpio_port_pkg::APB_SETUP
                           : gpio_port_pkg::APB_IDLE;
        gpio_port_pkg::APB_SETUP:
          phase_ff <= gpio_port_pkg::APB_ACCESS;
        gpio_port_pkg::APB_ACCESS:
          phase_ff <= psel ? gpio_port_pkg::APB_SETUP
                           : gpio_port_pkg::APB_IDLE;
        default:
          phase_ff <= gpio_port_pkg::APB_IDLE;
      endcase
    end
  end

  // Zero-wait slave: the access phase completes on its first edge
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr_ok = (paddr == `OFS_PIN_DATA_DIR) |
                   (paddr == `OFS_PIN_EVT_STS_EN) |
                   (paddr == `OFS_PIN_CFG) |
                   (paddr == `OFS_SYS_EVT);

  // Timestamp enable overrides direction bit
  assign eff_output = pin_direction_bits_ff | ts_output_en_ff;

  // Polarity selects which level counts as active
  assign level_active = ~(pin_sync ^ pin_trigger_polarity_ff);

  // Minimum hold qualifier, one stage per cycle of the minimum
  logic [NPINS-1:0] hold_sr_ff [`MIN_LEVEL_CYC];  // Level history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `MIN_LEVEL_CYC; i++) begin
        hold_sr_ff[i] <= '0;
      end
    end else begin
      hold_sr_ff[0] <= level_active;
      for (int i = 1; i < `MIN_LEVEL_CYC; i++) begin
        hold_sr_ff[i] <= hold_sr_ff[i-1] & level_active;
      end
    end
  end
  // Sync stages hold reset zeros for two edges; a low-active pin
  // would otherwise raise a false event right after reset
  logic [1:0] sync_fill_ff;  // Fills with ones as real samples arrive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_fill_ff <= 2'h0;
    end else begin
      sync_fill_ff <= {sync_fill_ff[0], 1'b1};
    end
  end

  // Active now and in the previous sampled cycles, real samples only
  assign hold_ok = level_active & hold_sr_ff[`MIN_LEVEL_CYC-1] &
                   {NPINS{sync_fill_ff[1]}};

  // Flag update: set wins over write-one clear, enable not consulted
  always_comb begin
    nxt_flags = pin_event_flags_ff;
    if (wr_en && paddr == `OFS_PIN_EVT_STS_EN) begin
      nxt_flags = nxt_flags & ~pwdata[`FLAG_LSB +: NPINS];
    end
    nxt_flags = nxt_flags | hold_ok;
  end

  // Event flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_event_flags_ff <= `RST_BYTE;
    end else begin
      pin_event_flags_ff <= nxt_flags;
    end
  end

  // Direction and data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bits_ff <= `RST_BYTE;
      pin_data_bits_ff      <= `RST_BYTE;
    end else if (wr_en && paddr == `OFS_PIN_DATA_DIR) begin
      pin_direction_bits_ff <= pwdata[`DIR_LSB +: NPINS];
      pin_data_bits_ff      <= pwdata[`DATA_LSB +: NPINS];
    end
  end

  // Per-pin event enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_event_en_ff <= `RST_BYTE;
    end else if (wr_en && paddr == `OFS_PIN_EVT_STS_EN) begin
      pin_event_en_ff <= pwdata[`PEN_LSB +: NPINS];
    end
  end

  // Pin configuration: driver type, timestamp override, polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_driver_type_ff      <= `RST_BYTE;
      ts_output_en_ff         <= `RST_BYTE;
      pin_trigger_polarity_ff <= `RST_BYTE;
    end else if (wr_en && paddr == `OFS_PIN_CFG) begin
      pin_driver_type_ff      <= pwdata[`DRV_LSB +: NPINS];
      ts_output_en_ff         <= pwdata[`TSOE_LSB +: NPINS];
      pin_trigger_polarity_ff <= pwdata[`POL_LSB +: NPINS];
    end
  end

  // Enabled flags merge into the single port event
  assign nxt_port_event = |(nxt_flags & pin_event_en_ff);

  // Port event enable and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_event_en_ff <= 1'b0;
      sys_evt_mask_ff  <= 1'b0;
    end else if (wr_en && paddr == `OFS_SYS_EVT) begin
      port_event_en_ff <= pwdata[`PORT_EN_BIT];
      sys_evt_mask_ff  <= pwdata[`PORT_EN_BIT + 8];
    end
  end

  // Sticky system status: set beats the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_evt_sts_ff <= 1'b0;
    end else if (nxt_port_event) begin
      sys_evt_sts_ff <= 1'b1;
    end else if (rd_en && paddr == `OFS_SYS_EVT) begin
      sys_evt_sts_ff <= 1'b0;
    end
  end

  // Registered port event and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_event <= 1'b0;
      irq        <= 1'b0;
    end else begin
      port_event <= nxt_port_event;
      // Needs both port enable and unmasked sticky status
      irq <= port_event_en_ff & sys_evt_mask_ff &
             (sys_evt_sts_ff | nxt_port_event);
    end
  end

  // Drivers: push/pull follows data, open drain only pulls low
  always_comb begin
    nxt_out = pin_data_bits_ff;
    nxt_oe  = eff_output & (pin_driver_type_ff | ~pin_data_bits_ff);
  end

  // Registered pad outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= nxt_out;
      pin_oe  <= nxt_oe;
    end
  end

  // Data read view: written value for outputs, live level for inputs
  assign rd_data_bits = (eff_output & pin_data_bits_ff) |
                        (~eff_output & pin_sync);

  // Read mux, reserved bits zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_PIN_DATA_DIR: begin
        nxt_prdata[`DIR_LSB +: NPINS]  = pin_direction_bits_ff;
        nxt_prdata[`DATA_LSB +: NPINS] = rd_data_bits;
      end
      `OFS_PIN_EVT_STS_EN: begin
        nxt_prdata[`PEN_LSB +: NPINS]  = pin_event_en_ff;
        nxt_prdata[`FLAG_LSB +: NPINS] = pin_event_flags_ff;
      end
      `OFS_PIN_CFG: begin
        nxt_prdata[`DRV_LSB +: NPINS]  = pin_driver_type_ff;
        nxt_prdata[`TSOE_LSB +: NPINS] = ts_output_en_ff;
        nxt_prdata[`POL_LSB +: NPINS]  = pin_trigger_polarity_ff;
      end
      `OFS_SYS_EVT: begin
        nxt_prdata[`PORT_EN_BIT]      = port_event_en_ff;
        nxt_prdata[`PORT_EN_BIT + 8]  = sys_evt_mask_ff;
        nxt_prdata[`PORT_EN_BIT + 16] = sys_evt_sts_ff;
      end
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Bus answer registered in setup, valid through access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Checks
  property p_dir_rst;
    @(posedge pclk) $rose(presetn) |-> pin_oe == '0;
  endproperty
  a_dir_rst: assert property (p_dir_rst)
    else $error("pins not inputs after reset");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      hold_ok[0] |=> pin_event_flags_ff[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("held level did not set flag");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_PIN_EVT_STS_EN && pwdata[0] && !hold_ok[0])
      |=> !pin_event_flags_ff[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      (pin_event_flags_ff[0] && !(wr_en && paddr == `OFS_PIN_EVT_STS_EN
       && pwdata[`FLAG_LSB])) |=> pin_event_flags_ff[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without write one");

  property p_port_evt;
    @(posedge pclk) disable iff (!presetn)
      ##1 port_event == |($past(nxt_flags) & $past(pin_event_en_ff));
  endproperty
  a_port_evt: assert property (p_port_evt)
    else $error("port event mismatch");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      irq |-> $past(port_event_en_ff);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without port enable");

  property p_od;
    @(posedge pclk) disable iff (!presetn)
      (!pin_driver_type_ff[0] && pin_data_bits_ff[0]) |=> !pin_oe[0];
  endproperty
  a_od: assert property (p_od)
    else $error("open drain drove a one");

  property p_ts_oe;
    @(posedge pclk) disable iff (!presetn)
      (ts_output_en_ff[0] && pin_driver_type_ff[0]) |=> pin_oe[0];
  endproperty
  a_ts_oe: assert property (p_ts_oe)
    else $error("timestamp override not driving");

  property p_rd_in;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `OFS_PIN_DATA_DIR
       && !eff_output[0]) |=> prdata[0] == $past(pin_sync[0]);
  endproperty
  a_rd_in: assert property (p_rd_in)
    else $error("input read wrong");

  property p_rd_out;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `OFS_PIN_DATA_DIR
       && eff_output[0]) |=> prdata[0] == $past(pin_data_bits_ff[0]);
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output read wrong");

  c_flag: cover property (@(posedge pclk) $rose(pin_event_flags_ff[0]));
  c_irq: cover property (@(posedge pclk) $rose(irq));
  c_err: cover property (@(posedge pclk) pslverr);
  c_acc: cover property (@(posedge pclk)
    phase_ff == gpio_port_pkg::APB_ACCESS);
endmodule
`default_nettype wire

// >>> bench/tb_gpio_data_direction_irq.sv
// Self-checking bench for the eight-pin port with level events
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_data_direction_irq;
  logic        pclk;        // Bus clock, 40 ns
  logic        presetn;     // Async reset, active low
  logic        psel;        // APB select
  logic        penable;     // APB access phase
  logic        pwrite;      // APB direction
  logic [11:0] paddr;       // APB byte address
  logic [31:0] pwdata;      // APB write data
  logic [31:0] prdata;      // APB read data
  logic        pready;      // APB answer
  logic        pslverr;     // APB error
  logic [7:0]  pin_in;      // Pin levels seen by the port
  logic [7:0]  pin_out;     // Pad data
  logic [7:0]  pin_oe;      // Pad drive enables
  logic        port_event;  // Merged enabled flags
  logic        irq;         // Host interrupt
  int          mismatches;  // Failed comparisons
  int          tests_run;   // All comparisons
  int          cycles;      // Hang guard
  logic [31:0] rd;          // Last read word
  logic        er;          // Last error bit

  gpio_data_direction_irq dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_event(port_event),
    .irq(irq)
  );

  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Cut a hang short; ceiling far above the roughly 160 cycles needed
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare one word, four-state exact
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare it
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask

  // Idle cycles for level paths to settle
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Reset values; all pins high so no low-level event fires
  task automatic t_reset();
    rdchk(12'h1E4, 32'h000000FF);
    rdchk(12'h1E8, 32'h00000000);
    rdchk(12'h1EC, 32'h00000000);
    chk("oe", 32'h0, {24'h0, pin_oe});
  endtask

  // Push/pull outputs on low nibble, inputs on high
  task automatic t_push();
    apb(1'b1, 12'h1EC, 32'h000000FF);
    apb(1'b1, 12'h1E4, 32'h000F00A5);
    pin_in <= 8'h3C;
    idle(4);
    chk("oe", 32'h0F, {24'h0, pin_oe});
    chk("out", 32'h05, {24'h0, pin_out & pin_oe});
    rdchk(12'h1E4, 32'h000F0035);
  endtask

  // Open drain: only zeros are driven, and driven low
  task automatic t_drain();
    apb(1'b1, 12'h1EC, 32'h00000000);
    apb(1'b1, 12'h1E4, 32'h00FF00F0);
    idle(2);
    chk("oe", 32'h0F, {24'h0, pin_oe});
    chk("out", 32'h00, {24'h0, pin_out & pin_oe});
  endtask

  // Timestamp enable overrides direction for drive and read-back
  task automatic t_stamp();
    apb(1'b1, 12'h1EC, 32'h0000F0FF);
    apb(1'b1, 12'h1E4, 32'h000000A5);
    pin_in <= 8'h0F;
    idle(4);
    chk("oe", 32'hF0, {24'h0, pin_oe});
    rdchk(12'h1E4, 32'h000000AF);
    apb(1'b1, 12'h1EC, 32'h00FF00FF);
    apb(1'b1, 12'h1E4, 32'h00000000);
  endtask

  // Flags, enables, port event and the interrupt chain
  task automatic t_event();
    pin_in <= 8'h00;
    idle(6);
    apb(1'b1, 12'h1E8, 32'h000000FF);
    rdchk(12'h1E8, 32'h00000000);
    pin_in <= 8'h04;
    idle(2);
    pin_in <= 8'h00;                // Short pulse, 80 ns
    idle(6);
    rdchk(12'h1E8, 32'h00000004);
    chk("event", 32'h0, {31'h0, port_event});
    apb(1'b1, 12'h1E8, 32'h00040000);
    idle(2);
    chk("event", 32'h1, {31'h0, port_event});
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h1F0, 32'h00000100);
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h1F0, 32'h00000101);
    idle(2);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h1E8, 32'h00040004);
    idle(2);
    rdchk(12'h1E8, 32'h00040000);
    chk("event", 32'h0, {31'h0, port_event});
    rdchk(12'h1F0, 32'h00010101);
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    // Level still present: clearing must not stick
    pin_in <= 8'h20;
    idle(6);
    apb(1'b1, 12'h1E8, 32'h00040020);
    idle(2);
    rdchk(12'h1E8, 32'h00040020);
    pin_in <= 8'h00;
    idle(4);
    apb(1'b1, 12'h1E8, 32'h00040020);
    // Pin 3 set to trigger on the low level
    apb(1'b1, 12'h1EC, 32'h00F700FF);
    idle(6);
    rdchk(12'h1E8, 32'h00040008);
  endtask

  // Unmapped address: write ignored, read zero with error
  task automatic t_bad();
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk("bad rd", 32'h0, rd);
    chk("bad err", 32'h1, {31'h0, er});
    rdchk(12'h1E4, 32'h00000000);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_in = 8'hFF;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    idle(4);
    t_reset();
    t_push();
    t_drain();
    t_stamp();
    t_event();
    t_bad();
    end_of_test();
  end
endmodule
`default_nettype wire
